// ==== wdsl_pkg.sv ====
// shared constants and types for the watchdog with safety levels
package wdsl_pkg;
    // register bus
    localparam int ADDR_W = 4;
    localparam int DATA_W = 8;
    localparam logic [3:0] CTRL_OFFSET = 4'h0;
    localparam logic [3:0] STAT_OFFSET = 4'h1;

    // watchdog_control field positions
    localparam int PERIOD_LSB = 0;
    localparam int PERIOD_W = 3;
    localparam int ON_BIT = 3;
    localparam int UNLOCK_BIT = 4;

    // reset status field position
    localparam int FLAG_BIT = 3;

    // values after reset
    localparam logic [2:0] PERIOD_RESET = 3'h0;
    localparam logic ON_RESET = 1'b0;
    localparam logic [7:0] RDATA_RESET = 8'h00;

    // unlock window length in cpu clock cycles
    localparam logic [2:0] UNLOCK_CYCLES = 3'h4;

    // nominal oscillator and cpu clock rates
    localparam int OSC_FREQ_MHZ = 1;
    localparam int CLK_FREQ_MHZ = 100;
    localparam int CLK_PER_OSC = CLK_FREQ_MHZ / OSC_FREQ_MHZ;

    // base time-out in oscillator cycles, scaled by 2**period
    localparam int BASE_OSC_CYCLES = 16384;
    localparam int COUNT_W = 21;

    typedef enum logic [1:0] {
        WDSL_LEVEL0,
        WDSL_LEVEL1,
        WDSL_LEVEL2
    } wdsl_level_e;

    // register bus request
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic wr;
        logic rd;
    } wdsl_bus_s;
endpackage

// ==== wdsl_watchdog.sv ====
// watchdog timer with fuse-selected safety levels and timed unlock
`timescale 1ns/1ps

// Overview of operation
// - counter advances on separate on-chip oscillator
// - count restarts on kick, disable, reset
// - expiry while enabled resets the chip
// - time-out is 16384 times two**period
// - period in bits 2..0, used when enabled
// - two fuses select safety level
// - levels 0,1 start disabled, enable freely
// - writing enable one always accepted
// - level 2 always enabled, reads one
// - level 2 can never be disabled
// - bits 7..5 read as zero
// - unlock bit self-clears after four cycles
// - enable cleared only while unlock is set
// - level 0 period changes unrestricted
// - level 2 period unlock, enable ignored
// - one-cycle reset pulse, delay starts after
// - reset flag set, cleared by por/write
module wdsl_watchdog
    import wdsl_pkg::*;
#(
    parameter int BASE_CYCLES = BASE_OSC_CYCLES
) (
    // clock and resets
    input wire logic clock,
    input wire logic rstn,
    input wire logic power_on_rstn,
    // register bus
    input wire wdsl_bus_s bus,
    output logic [DATA_W-1:0] rdata,
    // watchdog-reset instruction strobe from the core
    input wire logic kick,
    // oscillator and fuses, asynchronous pins (high = programmed)
    input wire logic dog_osc,
    input wire logic legacy_compat_fuse,
    input wire logic always_on_fuse,
    // reset outputs
    output logic dog_reset_pulse,
    output logic reset_delay_start,
    output logic dog_reset_flag,
    output logic dog_enabled
);

    logic [2:0] osc_sync_q;
    logic [1:0] compat_sync_q;
    logic [1:0] always_sync_q;
    wdsl_level_e level;
    logic osc_edge;
    logic on_q;
    logic [2:0] period_q;
    logic [2:0] unlock_cnt_q;
    logic unlock_open;
    logic on_eff;
    logic ctrl_wr;
    logic stat_wr;
    logic [COUNT_W-1:0] count_q;
    logic expire;
    logic pulse_q;
    logic trail_q;
    logic flag_q;
    logic [DATA_W-1:0] rdata_q;

    // time-out length for a period code
    function automatic logic [COUNT_W-1:0] limit_of(input logic [2:0] p);
        logic [COUNT_W:0] full;
        full = (COUNT_W+1)'(BASE_CYCLES) << p;
        limit_of = full[COUNT_W-1:0] - COUNT_W'(1);
    endfunction

    // two-flop synchronisers; third oscillator stage only for the edge
    // no reset here, so the fuse level is settled when chip reset ends
    always_ff @(posedge clock) begin
        osc_sync_q <= {osc_sync_q[1:0], dog_osc};
        compat_sync_q <= {compat_sync_q[0], legacy_compat_fuse};
        always_sync_q <= {always_sync_q[0], always_on_fuse};
    end

    // rising oscillator edge seen in cpu domain; osc far below clock rate
    assign osc_edge = osc_sync_q[1] & ~osc_sync_q[2];

    // safety level decode
    always_comb begin
        if (always_sync_q[1]) begin
            level = WDSL_LEVEL2;
        end else if (compat_sync_q[1]) begin
            level = WDSL_LEVEL0;
        end else begin
            level = WDSL_LEVEL1;
        end
    end

    assign ctrl_wr = bus.wr && (bus.addr == CTRL_OFFSET);
    assign stat_wr = bus.wr && (bus.addr == STAT_OFFSET);
    assign unlock_open = (unlock_cnt_q != 3'h0);
    // level 2 forces enable regardless of the stored bit
    assign on_eff = on_q | (level == WDSL_LEVEL2);

    // unlock window: opened by writing unlock and enable together
    always_ff @(posedge clock) begin
        if (!rstn) begin
            unlock_cnt_q <= 3'h0;
        end else if (ctrl_wr && bus.wdata[UNLOCK_BIT]
                     && bus.wdata[ON_BIT]) begin
            unlock_cnt_q <= UNLOCK_CYCLES;
        end else if (unlock_open) begin
            unlock_cnt_q <= unlock_cnt_q - 3'h1;
        end
    end

    // enable bit: set freely, cleared only inside the window
    always_ff @(posedge clock) begin
        if (!rstn) begin
            on_q <= ON_RESET;
        end else if (ctrl_wr) begin
            if (bus.wdata[ON_BIT]) begin
                on_q <= 1'b1;
            end else if (unlock_open && level != WDSL_LEVEL2) begin
                on_q <= 1'b0;
            end
        end
    end

    // period: free at level 0, else only in window with unlock clear
    always_ff @(posedge clock) begin
        if (!rstn) begin
            period_q <= PERIOD_RESET;
        end else if (ctrl_wr) begin
            if (level == WDSL_LEVEL0) begin
                period_q <= bus.wdata[PERIOD_LSB +: PERIOD_W];
            end else if (unlock_open && !bus.wdata[UNLOCK_BIT]) begin
                period_q <= bus.wdata[PERIOD_LSB +: PERIOD_W];
            end
        end
    end

    assign expire = on_eff && osc_edge
                    && (count_q >= limit_of(period_q));

    // time-out counter in oscillator cycles
    always_ff @(posedge clock) begin
        if (!rstn) begin
            count_q <= '0;
        end else if (kick || !on_eff || expire) begin
            count_q <= '0;
        end else if (osc_edge) begin
            count_q <= count_q + COUNT_W'(1);
        end
    end

    // one-cycle reset pulse, then delay start on its trailing edge
    always_ff @(posedge clock) begin
        if (!rstn) begin
            pulse_q <= 1'b0;
            trail_q <= 1'b0;
        end else begin
            pulse_q <= expire;
            trail_q <= pulse_q;
        end
    end

    // reset flag survives chip reset; a new expiry beats a clear write
    always_ff @(posedge clock) begin
        if (!power_on_rstn) begin
            flag_q <= 1'b0;
        end else if (pulse_q) begin
            flag_q <= 1'b1;
        end else if (stat_wr && !bus.wdata[FLAG_BIT]) begin
            flag_q <= 1'b0;
        end
    end

    // read data one cycle after the strobe, zero otherwise
    always_ff @(posedge clock) begin
        if (!rstn) begin
            rdata_q <= RDATA_RESET;
        end else if (bus.rd && bus.addr == CTRL_OFFSET) begin
            rdata_q <= {3'h0, unlock_open, on_eff, period_q};
        end else if (bus.rd && bus.addr == STAT_OFFSET) begin
            rdata_q <= 8'(flag_q) << FLAG_BIT;
        end else begin
            rdata_q <= RDATA_RESET;
        end
    end

    assign rdata = rdata_q;
    assign dog_reset_pulse = pulse_q;
    assign reset_delay_start = trail_q;
    assign dog_reset_flag = flag_q;
    assign dog_enabled = on_eff;

endmodule

// ==== wdsl_watchdog_monitor.sv ====
// port assertions for the watchdog
`timescale 1ns/1ps
module wdsl_watchdog_monitor
    import wdsl_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic rstn,
    // watched ports
    input wire wdsl_bus_s bus,
    input wire logic [DATA_W-1:0] rdata,
    input wire logic always_on_fuse,
    input wire logic dog_reset_pulse,
    input wire logic reset_delay_start,
    input wire logic dog_reset_flag,
    input wire logic dog_enabled
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rstn);
    // time-out pulse followed by the delay start
    sequence fire_s;
        dog_reset_pulse ##1 reset_delay_start && !dog_reset_pulse;
    endsequence
    pulse_tail_a: assert property (dog_reset_pulse |-> fire_s)
        else $error("bad pulse or delay start");
    delay_cause_a: assert property (reset_delay_start |-> $past(dog_reset_pulse))
        else $error("delay start without pulse");
    flag_set_a: assert property (fire_s |-> dog_reset_flag)
        else $error("flag not set");
    flag_cause_a: assert property ($rose(dog_reset_flag) |-> $past(dog_reset_pulse))
        else $error("flag set without pulse");
    fire_on_a: assert property (dog_reset_pulse |-> $past(dog_enabled))
        else $error("pulse while disabled");
    // sync flops may lag the fuse, so wait four steady cycles
    lvl2_on_a: assert property ((rstn && always_on_fuse)[*4] |-> dog_enabled)
        else $error("level 2 not enabled");
    rsv_zero_a: assert property (bus.rd |=> rdata[7:5] == 3'h0)
        else $error("reserved bits set");
    off_cause_a: assert property ($fell(dog_enabled) |-> $past(bus.wr) &&
        $past(bus.addr) == CTRL_OFFSET && $past(bus.wdata[ON_BIT]) == 1'b0)
        else $error("enable dropped without write");
endmodule
bind wdsl_watchdog wdsl_watchdog_monitor u_mon (.clock, .rstn, .bus, .rdata,
    .always_on_fuse, .dog_reset_pulse, .reset_delay_start, .dog_reset_flag,
    .dog_enabled);

// ==== wdsl_watchdog_test.sv ====
// self-checking bench for the watchdog with safety levels
`timescale 1ns/1ps
module wdsl_watchdog_test;
    import wdsl_pkg::*;
    logic clock = 0, rstn = 0, power_on_rstn = 0, kick = 0, dog_osc = 0;
    logic lc = 0, ao = 0, pulse, dly, flag, en, pend = 0, mflag = 0;
    logic [7:0] rdata, exp_q, d;
    logic [8:0] seq [7] = '{9'h100, 9'h00e, 9'h000, 9'h018, 9'h100,
        9'h005, 9'h100};
    wdsl_bus_s bus = '0;
    int fail_count = 0, total_checks = 0, cyc = 0, osc_n = 0;
    int seed = 32'h90f9b484, on, per, unl, lvl, r, n;
    wdsl_watchdog #(.BASE_CYCLES(4)) u_dut (.clock, .rstn, .power_on_rstn,
        .bus, .rdata, .kick, .dog_osc, .legacy_compat_fuse(lc),
        .always_on_fuse(ao), .dog_reset_pulse(pulse),
        .reset_delay_start(dly), .dog_reset_flag(flag), .dog_enabled(en));
    // clock, and an oscillator kept slow so the sync flops see every edge
    always #5 clock = ~clock;
    always begin
        repeat (5) @(posedge clock);
        dog_osc <= ~dog_osc;
        osc_n += !dog_osc;
    end
    // hang guard
    always @(posedge clock) begin
        if (++cyc == 20000) begin
            fail_count++;
            summarize;
        end
    end
    // compare away from the edge so design updates have landed
    always @(negedge clock) begin
        if (pulse) mflag = 1;
        if (pend) chk(rdata, exp_q);
        if (rstn) chk({7'h0, en}, {7'h0, on != 0 || lvl == 2});
    end
    task automatic chk(logic [7:0] got, logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic summarize;
        if (fail_count == 0 && total_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    function automatic logic [7:0] rd_val(logic [3:0] a);
        if (a == CTRL_OFFSET) return {3'h0, unl > 0, on != 0 || lvl == 2,
            3'(per)};
        return a == STAT_OFFSET ? {4'h0, mflag, 3'h0} : 8'h00;
    endfunction
    // one bus cycle, with the reference model stepped at its edge
    task automatic op(logic w, logic rd, logic k, logic [3:0] a,
        logic [7:0] d);
        logic open;
        bus <= '{addr: a, wdata: d, wr: w, rd: rd};
        kick <= k;
        @(posedge clock);
        open = unl > 0;
        pend = rd;
        exp_q = rd_val(a);
        unl = open ? unl - 1 : 0;
        if (w && a == STAT_OFFSET && !d[3]) mflag = 0;
        if (w && a == CTRL_OFFSET) begin
            if (lvl == 0 || (open && !d[4])) per = d[2:0];
            if (d[3]) on = 1;
            else if (open && lvl != 2) on = 0;
            if (d[4] && d[3]) unl = 4;
        end
    endtask
    task automatic rst(int l);
        bus <= '0;
        kick <= 0;
        rstn <= 0;
        lc <= l == 0 || l == 3;
        ao <= l > 1;
        pend = 0;
        repeat (3) @(posedge clock);
        rstn <= 1;
        power_on_rstn <= 1;
        lvl = l > 1 ? 2 : l;
        {on, per, unl} = 0;
    endtask
    // levels in turn, then the time-out of every period code
    initial begin
        for (int l = 0; l < 4; l++) begin
            rst(l);
            foreach (seq[i]) op(!seq[i][8], seq[i][8], 0, CTRL_OFFSET, seq[i][7:0]);
            repeat (5) op(0, 0, 0, 4'h0, 8'h00);
            op(0, 1, 0, CTRL_OFFSET, 8'h00);
            repeat (60) begin
                r = $random(seed);
                d = r[15:8];
                d[3] = d[3] | d[4];
                op(r[0], !r[0], 1, r[2] ? r[7:4] : {3'h0, r[3]}, d);
            end
        end
        rst(0);
        for (int p = 0; p < 8; p++) begin
            op(1, 0, 1, CTRL_OFFSET, 8'h08 | 8'(p));
            n = osc_n;
            op(1, 0, 0, STAT_OFFSET, 8'h00);
            while (!mflag && cyc < 19000) op(0, 0, 0, 4'h0, 8'h00);
            n = osc_n - n - (4 << p);
            chk({7'h0, n >= -1 && n <= 1}, 8'h01);
            op(0, 1, 0, STAT_OFFSET, 8'h00);
        end
        op(0, 0, 0, 4'h0, 8'h00);
        summarize;
    end
endmodule
